// File: inc/isp_regs.svh
// Constants for the serial programming and boot command unit.
// Assumes a 200 MHz core clock and a host-driven serial shift clock.
// Contract
// R1: Forced reset release selects boot ROM at 0000, ignoring boot-select bit.
// R2: Host holds high voltage three instruction cycles past reset release.
// R3: Host sequence: isolate pin, supply, reset low, high voltage, release.
// R4: Unforced reset with boot-select bit set starts flash at 0000.
// R5: High voltage never clears boot-select or security bits.
// R6: Over serial commands only a mass erase clears the security bit.
// R7: While forcing pin is high, load clock drives the clock output pin; code enables the output from the high-voltage input instead.
// R8: Wait for forcing pin low, debounce, then enable command handling.
// R9: Exit command 0xD3 resets device and resumes from flash.
// R10: Host sends timing-setup 0x3B plus one value byte first.
// R11: Page erase 0xB3 with page address; returns nothing.
// R12: Mass erase 0xBF with confirmation byte erases all flash.
// R13: Read byte 0x1D returns data, 0xFF if secured, option at 0xFFFF.
// R14: Block read 0xA3 with address and count up to 32767.
// R15: Write byte 0x71 with address and data programs one location.
// R16: Block write 0x8F with address, count 0..16, then data bytes.
// R17: Host keeps every block write inside one 64-byte boundary.
// R18: Reset loads write pulse timing with the 10 MHz setting.
// R19: Unknown command bytes are ignored without side effects.
`ifndef ISP_REGS_SVH
`define ISP_REGS_SVH
`define OP_TIMING     8'h3B
`define OP_PAGE_ERASE 8'hB3
`define OP_MASS_ERASE 8'hBF
`define OP_READ_BYTE  8'h1D
`define OP_MULTI_READ 8'hA3
`define OP_WRITE_BYTE 8'h71
`define OP_MULTI_PROG 8'h8F
`define OP_EXIT       8'hD3
`define MASS_CONFIRM  8'h55
`define TIMING_RST    8'h7B
`define OPT_INIT      8'h00
`define OPT_FLEX_BIT  1
`define OPT_SEC_BIT   0
`define OPT_ADDR      16'hFFFF
`define BOOT_VECTOR   16'h0000
`define SECURED_BYTE  8'hFF
`define ERASED_BYTE   8'hFF
`define FLASH_WORDS   32768
`define PAGE_BYTES    64
`define MAX_READ_CNT  16'h7FFF
`define MAX_PROG_CNT  16'h0010
`define CLK_MHZ       200
`define DEBOUNCE_US   10
`define DEBOUNCE_CYC  (`DEBOUNCE_US * `CLK_MHZ)
`define LOAD_CLK_HALF 4
`endif

// File: inc/isp_pkg.sv
// Types shared by the serial programming unit.
// Assumes isp_regs.svh supplies the numeric constants.
package isp_pkg;
  typedef enum logic [2:0] {
    ST_WAIT  = 3'b000,
    ST_CMD   = 3'b001,
    ST_ARGS  = 3'b010,
    ST_ERASE = 3'b011,
    ST_SEND  = 3'b100,
    ST_WDATA = 3'b101
  } isp_state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] cnt;
  } xfer_t;
endpackage : isp_pkg

// File: hw/isp_boot_unit.sv
// Serial programming command unit with forced boot entry and byte FIFO.
// Assumes the host drives sck only inside frames, data MSB first.
`timescale 1ns/10ps
`include "isp_regs.svh"

module isp_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r, wp_nxt, rp_r, rp_nxt;
  logic             push, pop;
  always_comb begin
    in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
    out_valid = wp_r != rp_r;
    out_data  = mem_r[rp_r[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wp_nxt    = push ? wp_r + 1'b1 : wp_r;
    rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule : isp_byte_fifo

module isp_boot_unit (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       boot_force_hv,
  input  wire logic       boot_force_pin,
  output logic            load_clock_out_pin,
  output logic            load_clock_oe,
  input  wire logic       serial_shift_clock,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            boot_from_rom,
  output logic [15:0]     boot_vector,
  output logic            isp_enabled,
  output logic            self_reset,
  output logic [7:0]      write_pulse_timing_reg,
  output logic [7:0]      option_reg
);
  import isp_pkg::*;

  logic [1:0] rst_sh_r;
  logic       rst_s;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rst_sh_r <= 2'b00;
    else          rst_sh_r <= {rst_sh_r[0], 1'b1};
  end
  assign rst_s = rst_sh_r[1];

  // Link domain: shifts bytes in and out on the host clock
  logic [2:0] bit_r, bit_nxt;
  logic [6:0] rsh_r, rsh_nxt;
  logic [7:0] rx_byte_r, rx_byte_nxt, tsh_r, tsh_nxt;
  logic       rx_tog_r, rx_tog_nxt, tx_ack_r, tx_ack_nxt;
  logic [1:0] txt_sync_r;
  logic       tx_tog_r;
  logic [7:0] tx_hold_r;
  always_comb begin
    bit_nxt     = bit_r + 3'd1;
    rsh_nxt     = {rsh_r[5:0], sdi};
    rx_byte_nxt = rx_byte_r;
    rx_tog_nxt  = rx_tog_r;
    tsh_nxt     = {tsh_r[6:0], 1'b1};
    tx_ack_nxt  = tx_ack_r;
    if (bit_r == 3'd7) begin
      rx_byte_nxt = {rsh_r, sdi};
      rx_tog_nxt  = ~rx_tog_r;
      // Idle bytes read as all ones when nothing is queued
      tsh_nxt     = `SECURED_BYTE;
      if (txt_sync_r[1] != tx_ack_r) begin
        tsh_nxt    = tx_hold_r;
        tx_ack_nxt = txt_sync_r[1];
      end
    end
  end
  // Sck may stop between frames, so reset acts without it
  always_ff @(posedge serial_shift_clock or negedge rst_s) begin
    if (!rst_s) begin
      bit_r      <= 3'd0;
      rsh_r      <= 7'h00;
      rx_byte_r  <= 8'h00;
      rx_tog_r   <= 1'b0;
      tsh_r      <= 8'hFF;
      tx_ack_r   <= 1'b0;
      txt_sync_r <= 2'b00;
    end else begin
      bit_r      <= bit_nxt;
      rsh_r      <= rsh_nxt;
      rx_byte_r  <= rx_byte_nxt;
      rx_tog_r   <= rx_tog_nxt;
      tsh_r      <= tsh_nxt;
      tx_ack_r   <= tx_ack_nxt;
      txt_sync_r <= {txt_sync_r[0], tx_tog_r};
    end
  end
  assign sdo = tsh_r[7];

  // Core-side synchronisers
  logic [1:0] rxt_sync_r, ack_sync_r, hv_sync_r, lvl_sync_r;
  logic       rxt_seen_r, pend_r, pend_nxt, rxt_seen_nxt;
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      rxt_sync_r <= 2'b00;
      ack_sync_r <= 2'b00;
    end else begin
      rxt_sync_r <= {rxt_sync_r[0], rx_tog_r};
      ack_sync_r <= {ack_sync_r[0], tx_ack_r};
    end
  end
  // Pin levels must be settled at reset release, so these run through reset
  always_ff @(posedge clk) begin
    hv_sync_r  <= {hv_sync_r[0], boot_force_hv};
    lvl_sync_r <= {lvl_sync_r[0], boot_force_pin};
  end

  logic       fifo_in_ready, fifo_valid, fifo_pop;
  logic [7:0] fifo_data;
  // Back-pressure holds the byte pending while the FIFO is full
  always_comb begin
    rxt_seen_nxt = rxt_sync_r[1];
    pend_nxt     = pend_r;
    if (pend_r && fifo_in_ready) pend_nxt = 1'b0;
    if (rxt_sync_r[1] != rxt_seen_r) pend_nxt = 1'b1;
  end
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      rxt_seen_r <= 1'b0;
      pend_r     <= 1'b0;
    end else begin
      rxt_seen_r <= rxt_seen_nxt;
      pend_r     <= pend_nxt;
    end
  end

  isp_byte_fifo #(.WIDTH(8), .DEPTH(8)) rx_fifo (
    .clk       (clk),
    .rst_n     (rst_s),
    .in_valid  (pend_r),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_byte_r),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Flash array and option byte are nonvolatile: no reset
  logic [7:0]  flash_r [`FLASH_WORDS];
  logic [7:0]  opt_r = `OPT_INIT;
  logic [7:0]  opt_nxt;
  logic        mem_we;
  logic [14:0] mem_addr;
  logic [7:0]  mem_wdata;
  always_ff @(posedge clk) begin
    if (mem_we) flash_r[mem_addr] <= mem_wdata;
    opt_r <= opt_nxt;
  end

  isp_state_t  st_r, st_nxt;
  xfer_t       xf_r, xf_nxt;
  logic [7:0]  op_r, op_nxt, tim_r, tim_nxt, tx_byte_nxt;
  logic [2:0]  argn_r, argn_nxt;
  logic [15:0] ecnt_r, ecnt_nxt;
  logic        mass_r, mass_nxt, tx_push, tx_busy;
  logic        boot_rom_r, boot_rom_nxt, en_r, en_nxt, srst_r, srst_nxt;
  logic        started_r, load_r, load_nxt;
  logic [11:0] deb_r, deb_nxt;
  logic [2:0]  ldiv_r, ldiv_nxt;
  logic [7:0]  rd_byte;

  assign tx_busy = tx_tog_r != ack_sync_r[1];
  always_comb begin
    if (xf_r.addr == `OPT_ADDR) rd_byte = opt_r; // R13
    else if (opt_r[`OPT_SEC_BIT] || xf_r.addr[15])
      rd_byte = `SECURED_BYTE; // R13 R14
    else rd_byte = flash_r[xf_r.addr[14:0]];
  end

  always_comb begin
    st_nxt       = st_r;
    xf_nxt       = xf_r;
    op_nxt       = op_r;
    tim_nxt      = tim_r;
    argn_nxt     = argn_r;
    ecnt_nxt     = ecnt_r;
    mass_nxt     = mass_r;
    opt_nxt      = opt_r;
    boot_rom_nxt = boot_rom_r;
    en_nxt       = en_r;
    srst_nxt     = 1'b0;
    deb_nxt      = deb_r;
    fifo_pop     = 1'b0;
    tx_push      = 1'b0;
    tx_byte_nxt  = rd_byte;
    mem_we       = 1'b0;
    mem_addr     = xf_r.addr[14:0];
    mem_wdata    = fifo_data;
    ldiv_nxt     = ldiv_r + 3'd1;
    load_nxt     = load_r;
    if (ldiv_r == 3'(`LOAD_CLK_HALF - 1)) begin
      ldiv_nxt = 3'd0;
      load_nxt = ~load_r;
    end
    unique case (st_r)
      ST_WAIT: begin
        // Pin reads high while forced; wait for a stable low
        if (!boot_rom_r || lvl_sync_r[1]) deb_nxt = 12'd0;
        else if (deb_r != 12'(`DEBOUNCE_CYC)) deb_nxt = deb_r + 12'd1;
        else begin
          en_nxt = 1'b1; // R8
          st_nxt = ST_CMD;
        end
      end
      ST_CMD: begin
        fifo_pop = fifo_valid;
        argn_nxt = 3'd0;
        op_nxt   = fifo_data;
        if (fifo_valid) begin
          unique case (fifo_data)
            `OP_TIMING, `OP_MASS_ERASE: st_nxt = ST_ARGS;
            `OP_PAGE_ERASE, `OP_READ_BYTE: st_nxt = ST_ARGS;
            `OP_MULTI_READ, `OP_WRITE_BYTE: st_nxt = ST_ARGS;
            `OP_MULTI_PROG: st_nxt = ST_ARGS;
            `OP_EXIT: begin
              srst_nxt     = 1'b1; // R9
              boot_rom_nxt = 1'b0; // R9
              en_nxt       = 1'b0;
              st_nxt       = ST_WAIT;
            end
            default: st_nxt = ST_CMD; // R19
          endcase
        end
      end
      ST_ARGS: begin
        fifo_pop = fifo_valid;
        if (fifo_valid) begin
          argn_nxt = argn_r + 3'd1;
          st_nxt   = ST_CMD;
          if (argn_r < 3'd2) xf_nxt.addr = {xf_r.addr[7:0], fifo_data};
          else               xf_nxt.cnt  = {xf_r.cnt[7:0], fifo_data};
          unique case (op_r)
            `OP_TIMING: tim_nxt = fifo_data;
            `OP_MASS_ERASE: begin
              if (fifo_data == `MASS_CONFIRM) begin
                mass_nxt = 1'b1; // R12
                ecnt_nxt = 16'h0000;
                st_nxt   = ST_ERASE;
              end
            end
            `OP_PAGE_ERASE: begin
              if (argn_r == 3'd1) begin
                mass_nxt = 1'b0; // R11
                ecnt_nxt = 16'h0000;
                xf_nxt.addr[5:0] = 6'h00;
                st_nxt   = ST_ERASE;
              end else st_nxt = ST_ARGS;
            end
            `OP_READ_BYTE: begin
              xf_nxt.cnt = 16'h0001; // R13
              st_nxt = (argn_r == 3'd1) ? ST_SEND : ST_ARGS;
            end
            `OP_MULTI_READ: begin
              if (argn_r == 3'd3) begin
                xf_nxt.cnt[15] = 1'b0; // R14
                st_nxt = ST_SEND;
              end else st_nxt = ST_ARGS;
            end
            `OP_WRITE_BYTE: begin
              if (argn_r == 3'd1) begin
                xf_nxt.cnt  = 16'h0001; // R15
                st_nxt      = ST_WDATA;
              end else st_nxt = ST_ARGS;
            end
            default: begin
              if (argn_r == 3'd2) begin
                xf_nxt.addr = xf_r.addr;
                xf_nxt.cnt  = {8'h00, fifo_data};
                if (fifo_data == 8'h00) st_nxt = ST_CMD;
                else if (fifo_data > 8'(`MAX_PROG_CNT))
                  xf_nxt.cnt = `MAX_PROG_CNT; // R16
                if (fifo_data != 8'h00) st_nxt = ST_WDATA;
              end else st_nxt = ST_ARGS;
            end
          endcase
        end
      end
      ST_ERASE: begin
        // One byte per cycle keeps the array a single-port memory
        mem_we    = 1'b1;
        mem_wdata = `ERASED_BYTE;
        mem_addr  = mass_r ? ecnt_r[14:0] : (xf_r.addr[14:0] | 15'(ecnt_r));
        ecnt_nxt  = ecnt_r + 16'd1;
        if (mass_r ? ecnt_r == 16'(`FLASH_WORDS - 1)
                   : ecnt_r == 16'(`PAGE_BYTES - 1)) begin
          opt_nxt[`OPT_FLEX_BIT] = 1'b0; // R4
          if (mass_r) opt_nxt[`OPT_SEC_BIT] = 1'b0; // R6
          st_nxt = ST_CMD;
        end
        if (!mass_r && xf_r.addr[15]) mem_we = 1'b0;
      end
      ST_SEND: begin
        if (xf_r.cnt == 16'h0000) st_nxt = ST_CMD;
        else if (!tx_busy) begin
          tx_push     = 1'b1; // R13 R14
          xf_nxt.cnt  = xf_r.cnt - 16'd1;
          xf_nxt.addr = xf_r.addr + 16'd1;
        end
      end
      ST_WDATA: begin
        fifo_pop = fifo_valid;
        if (fifo_valid) begin
          mem_we = !xf_r.addr[15]; // R15 R16
          if (xf_r.addr == `OPT_ADDR) begin
            opt_nxt = fifo_data;
            // Security only ever clears through a mass erase
            opt_nxt[`OPT_SEC_BIT] = fifo_data[`OPT_SEC_BIT]
                                    | opt_r[`OPT_SEC_BIT]; // R6
          end
          xf_nxt.addr = xf_r.addr + 16'd1;
          xf_nxt.cnt  = xf_r.cnt - 16'd1;
          if (xf_r.cnt == 16'd1) st_nxt = ST_CMD;
        end
      end
      default: st_nxt = ST_WAIT;
    endcase
  end

  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      st_r      <= ST_WAIT;
      xf_r      <= '0;
      op_r      <= 8'h00;
      tim_r     <= `TIMING_RST; // R18
      argn_r    <= 3'd0;
      ecnt_r    <= 16'h0000;
      mass_r    <= 1'b0;
      en_r      <= 1'b0;
      srst_r    <= 1'b0;
      deb_r     <= 12'd0;
      ldiv_r    <= 3'd0;
      load_r    <= 1'b0;
      tx_tog_r  <= 1'b0;
      tx_hold_r <= 8'hFF;
    end else begin
      st_r      <= st_nxt;
      xf_r      <= xf_nxt;
      op_r      <= op_nxt;
      tim_r     <= tim_nxt;
      argn_r    <= argn_nxt;
      ecnt_r    <= ecnt_nxt;
      mass_r    <= mass_nxt;
      en_r      <= en_nxt;
      srst_r    <= srst_nxt;
      deb_r     <= deb_nxt;
      ldiv_r    <= ldiv_nxt;
      load_r    <= load_nxt;
      if (tx_push) begin
        tx_tog_r  <= ~tx_tog_r;
        tx_hold_r <= tx_byte_nxt;
      end
    end
  end

  // Boot source is caught on the first clock after reset release
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      started_r  <= 1'b0;
      boot_rom_r <= 1'b0;
    end else begin
      started_r <= 1'b1;
      if (!started_r)
        boot_rom_r <= hv_sync_r[1] || !opt_r[`OPT_FLEX_BIT]; // R1 R4 R5
      else
        boot_rom_r <= boot_rom_nxt;
    end
  end

  assign load_clock_out_pin     = load_r;
  assign load_clock_oe          = hv_sync_r[1] && rst_s; // R7
  assign boot_from_rom          = boot_rom_r;
  assign boot_vector            = `BOOT_VECTOR;
  assign isp_enabled            = en_r;
  assign self_reset             = srst_r;
  assign write_pulse_timing_reg = tim_r;
  assign option_reg             = opt_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s);
  timing_reset_a: assert property ($rose(started_r) |-> tim_r == 8'h7B) // R18
    else $error("timing register not at reset setting");
  forced_boot_a: assert property ($rose(started_r) // R1
      && $past(hv_sync_r[1]) |-> boot_rom_r)
    else $error("forced reset did not select boot rom");
  flash_boot_a: assert property ($rose(started_r) // R4
      && !$past(hv_sync_r[1]) && $past(opt_r[1]) |-> !boot_rom_r)
    else $error("unforced reset did not select flash");
  load_clock_a: assert property (hv_sync_r[1] && started_r // R7
      |-> load_clock_oe ##4 load_clock_out_pin
      != $past(load_clock_out_pin, 4))
    else $error("load clock not driven while forced");
  enable_wait_a: assert property ($rose(en_r) |-> $past(!lvl_sync_r[1]) // R8
      && $past(deb_r) == 12'd2000)
    else $error("commands enabled without debounced low");
  exit_reset_a: assert property (st_r == ST_CMD && fifo_valid // R9
      && fifo_data == 8'hD3 |=> self_reset ##1 !self_reset && !en_r)
    else $error("exit command did not reset");
  secure_mask_a: assert property (tx_push && opt_r[0] // R13
      && xf_r.addr != 16'hFFFF |-> tx_byte_nxt == 8'hFF)
    else $error("secured read leaked data");
  sec_clear_a: assert property ($fell(opt_r[0]) |-> $past(mass_r) // R6
      && $past(st_r) == ST_ERASE)
    else $error("security cleared without mass erase");
  bad_cmd_a: assert property (st_r == ST_CMD && fifo_valid // R19
      && !(fifo_data inside {8'h3B, 8'hB3, 8'hBF, 8'h1D, 8'hA3, 8'h71,
      8'h8F, 8'hD3}) |=> st_r == ST_CMD && $stable(xf_r) && $stable(opt_r))
    else $error("unknown command had an effect");
  prog_count_a: assert property (st_r == ST_WDATA |-> xf_r.cnt <= 16'd16) // R16
    else $error("block write count above limit");
endmodule : isp_boot_unit

// File: tb/isp_host_model.sv
// Host programmer model: clocks one byte at a time over the serial link.
// Assumes the device shifts sdi and updates sdo on the rising shift clock.
`timescale 1ns/10ps

module isp_host_model #(
  parameter real HALF_NS = 16.0
) (
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sck = 1'b0;
    sdi = 1'b1;
  end

  // Clock stands low between frames; idle data shows the last bit inverted
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #1;
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      #(HALF_NS);
      rx[i] = sdo;
      sck = 1'b1;
      #(HALF_NS);
      sck = 1'b0;
    end
    #1;
    sdi = ~tx[0];
  endtask : xfer
endmodule : isp_host_model

// File: tb/tb.sv
// Self-checking bench for the serial programming unit, FIFO via the link.
// Assumes isp_regs.svh constants and the host model on the serial link.
`timescale 1ns/10ps
`include "isp_regs.svh"

module tb;
  logic        clk, reset_n, boot_force_hv, boot_force_pin;
  logic        load_clock_out_pin, load_clock_oe, sck, sdi, sdo;
  logic        boot_from_rom, isp_enabled, self_reset;
  logic [15:0] boot_vector, a;
  logic [7:0]  write_pulse_timing_reg, option_reg, opt_m, b, d0, d1;
  logic [15:0] adr[4];
  logic [7:0]  mem_m[int];
  int          bad_count = 0, checks_done = 0, pulses = 0, rises = 0, n;

  isp_boot_unit dut (.clk(clk), .reset_n(reset_n),
    .boot_force_hv(boot_force_hv), .boot_force_pin(boot_force_pin),
    .load_clock_out_pin(load_clock_out_pin), .load_clock_oe(load_clock_oe),
    .serial_shift_clock(sck), .sdi(sdi), .sdo(sdo),
    .boot_from_rom(boot_from_rom), .boot_vector(boot_vector),
    .isp_enabled(isp_enabled), .self_reset(self_reset),
    .write_pulse_timing_reg(write_pulse_timing_reg), .option_reg(option_reg));
  isp_host_model host (.sck(sck), .sdi(sdi), .sdo(sdo));

  always #2.5 clk = ~clk;
  always @(posedge clk) if (self_reset === 1'b1) pulses++;
  always @(posedge load_clock_out_pin) rises++;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  task automatic tx(input logic [7:0] v);
    logic [7:0] r;
    host.xfer(v, r);
  endtask : tx

  task automatic cmd(input logic [7:0] op, input logic [15:0] ad);
    tx(op);
    tx(ad[15:8]);
    tx(ad[7:0]);
  endtask : cmd

  // Idle slots read 0xFF, so the first other byte is taken as the answer
  task automatic resp(output logic [7:0] v);
    v = 8'hFF;
    for (int i = 0; i < 6 && v === 8'hFF; i++) host.xfer(8'h00, v);
  endtask : resp

  function automatic logic [7:0] exp_rd(input logic [15:0] ad);
    if (ad == `OPT_ADDR) return opt_m;
    if (opt_m[`OPT_SEC_BIT] || ad[15] || !mem_m.exists(ad)) return 8'hFF;
    return mem_m[ad];
  endfunction : exp_rd

  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    cmd(`OP_WRITE_BYTE, ad);
    tx(d);
    if (ad == `OPT_ADDR) opt_m = d | (opt_m & 8'h01);
    else if (!ad[15]) mem_m[ad] = d;
    cyc(40);
  endtask : wr

  task automatic blk_rd(input logic [15:0] ad, input int k);
    logic [7:0] v;
    cmd(`OP_MULTI_READ, ad);
    tx(8'(k >> 8));
    tx(8'(k));
    for (int i = 0; i < k; i++) begin
      resp(v);
      check("block read", {8'h00, v}, {8'h00, exp_rd(ad + 16'(i))});
    end
    cyc(100);
  endtask : blk_rd

  task automatic rd(input logic [15:0] ad);
    logic [7:0] v;
    cmd(`OP_READ_BYTE, ad);
    resp(v);
    check("read byte", {8'h00, v}, {8'h00, exp_rd(ad)});
    cyc(20);
  endtask : rd

  initial begin
    #450000;
    bad_count++;
    print_verdict();
  end

  initial begin
    clk = 0;
    reset_n = 0;
    boot_force_hv = 0;
    boot_force_pin = 0;
    opt_m = `OPT_INIT;
    void'($urandom(93302));
    cyc(1);
    boot_force_hv = 1;
    boot_force_pin = 1;
    cyc(3);
    reset_n = 1;
    cyc(8);
    check("boot rom", 16'(boot_from_rom), 16'h0001);
    check("vector", boot_vector, `BOOT_VECTOR);
    check("timing reset", 16'(write_pulse_timing_reg), 16'(`TIMING_RST));
    check("option kept", 16'(option_reg), 16'(opt_m));
    n = rises;
    cyc(32);
    check("load clock", 16'(rises - n), 16'h0004);
    check("load oe", 16'(load_clock_oe), 16'h0001);
    check("held off", 16'(isp_enabled), 16'h0000);
    boot_force_hv = 0;
    boot_force_pin = 0;
    n = 0;
    while (isp_enabled !== 1'b1 && n < 2200) begin
      cyc(1);
      n++;
    end
    check("debounce", 16'(n >= 1990 && n < 2200), 16'h0001);
    check("oe off", 16'(load_clock_oe), 16'h0000);
    b = 8'($urandom);
    tx(`OP_TIMING);
    tx(b);
    cyc(20);
    check("timing", 16'(write_pulse_timing_reg), 16'(b));
    repeat (4) begin
      do b = 8'($urandom);
      while (b inside {`OP_TIMING, `OP_PAGE_ERASE, `OP_MASS_ERASE,
        `OP_READ_BYTE, `OP_MULTI_READ, `OP_WRITE_BYTE, `OP_MULTI_PROG,
        `OP_EXIT});
      tx(b);
    end
    cyc(20);
    check("unknown op", 16'(option_reg), 16'(opt_m));
    adr = '{16'h0000, 16'h7FFF, 16'h8000, 16'($urandom) & 16'h7FFF};
    foreach (adr[i]) wr(adr[i], 8'($urandom_range(254)));
    foreach (adr[i]) rd(adr[i]);
    // Page-tail start so the 16 bytes end exactly on the 64-byte edge
    a = {1'b0, 9'($urandom), 6'h30};
    cmd(`OP_MULTI_PROG, a);
    tx(8'h10);
    for (int i = 0; i < 16; i++) begin
      b = 8'($urandom_range(254));
      tx(b);
      mem_m[a + 16'(i)] = b;
    end
    cyc(100);
    blk_rd(a, 16);
    wr(`OPT_ADDR, 8'h03);
    check("option write", 16'(option_reg), 16'h0003);
    rd(a);
    rd(`OPT_ADDR);
    blk_rd(a, 4);
    cmd(`OP_PAGE_ERASE, a + 16'h0005);
    cyc(200);
    opt_m = 8'h01;
    check("page erase", 16'(option_reg), 16'(opt_m));
    wr(`OPT_ADDR, 8'h00);
    check("sec kept", 16'(option_reg), 16'(opt_m));
    tx(`OP_MASS_ERASE);
    tx(`MASS_CONFIRM ^ 8'h01);
    cyc(200);
    check("bad confirm", 16'(option_reg), 16'(opt_m));
    tx(`OP_MASS_ERASE);
    tx(`MASS_CONFIRM);
    opt_m = 8'h00;
    mem_m.delete();
    // Eight bytes fill the FIFO while the erase holds the reader off
    d0 = 8'($urandom_range(254));
    d1 = 8'($urandom_range(254));
    wr(a, d0);
    wr(a + 16'h0001, d1);
    check("queued", 16'(option_reg), 16'h0001);
    cyc(33000);
    check("mass erase", 16'(option_reg), 16'(opt_m));
    rd(a);
    rd(a + 16'h0001);
    rd(a + 16'h0002);
    wr(`OPT_ADDR, 8'h02);
    tx(`OP_EXIT);
    cyc(20);
    check("exit pulse", 16'(pulses), 16'h0001);
    check("exit flash", 16'(boot_from_rom), 16'h0000);
    check("exit idle", 16'(isp_enabled), 16'h0000);
    reset_n = 0;
    cyc(4);
    reset_n = 1;
    cyc(8);
    check("plain boot", 16'(boot_from_rom), 16'h0000);
    check("timing again", 16'(write_pulse_timing_reg), 16'(`TIMING_RST));
    check("option nv", 16'(option_reg), 16'h0002);
    // Forced entry again, now with the boot-select bit set
    reset_n = 0;
    cyc(1);
    boot_force_hv = 1;
    boot_force_pin = 1;
    cyc(3);
    reset_n = 1;
    cyc(8);
    check("forced again", 16'(boot_from_rom), 16'h0001);
    check("option forced", 16'(option_reg), 16'h0002);
    check("oe again", 16'(load_clock_oe), 16'h0001);
    print_verdict();
  end
endmodule : tb
